// >>> src/bbs_core.v
`timescale 1ns/1ns
`default_nettype none
`include "bbs_defs.vh"
module bbs_core (
	input  wire                       core_clk_i,
	input  wire                       reset_i,
	input  wire                       op_valid_i,
	input  wire [`BBS_OP_W-1:0]       op_code_i,
	input  wire [`BBS_RF_ADDR_W-1:0]  op_reg_i,
	input  wire [`BBS_IO_ADDR_W-1:0]  op_io_addr_i,
	input  wire [2:0]                 op_bit_i,
	input  wire [6:0]                 op_offset_i,
	output reg                        op_ready_o,
	output reg                        op_done_o,
	output reg  [`BBS_PC_W-1:0]       pc_o,
	output reg  [7:0]                 status_register_o,
	output reg  [7:0]                 result_o,
	output reg  [`BBS_IO_ADDR_W-1:0]  io_addr_o,
	output reg  [7:0]                 io_data_o,
	output reg                        io_we_o
);
	// ************************************************
	// state and storage
	// ************************************************
	localparam ST_IDLE = 2'b01;
	localparam ST_WAIT = 2'b10;

	reg [1:0]            state_reg;
	reg [7:0]            rf_mem [0:`BBS_RF_DEPTH-1];
	reg [7:0]            io_mem [0:`BBS_IO_DEPTH-1];
	reg [`BBS_PC_W-1:0]  pc_next;
	reg [7:0]            sr_next;
	reg [7:0]            rd_next;
	reg                  rd_we;
	reg                  taken;
	reg                  io_op;
	reg                  io_val;
	reg [7:0]            io_word;
	wire [7:0]           rd_val;
	wire [7:0]           sr;
	integer              i;

	assign rd_val = rf_mem[op_reg_i];
	assign sr     = status_register_o;

	// flags shared by all shift and rotate results
	function [7:0] shift_flags;
		input [7:0] sr_in;
		input [7:0] res;
		input       cout;
		reg   [7:0] f;
		begin
			f = sr_in;
			f[`BBS_FLAG_C] = cout;
			f[`BBS_FLAG_Z] = (res == 8'h00);
			f[`BBS_FLAG_N] = res[7];
			f[`BBS_FLAG_V] = res[7] ^ cout;
			shift_flags = f;
		end
	endfunction

	// ************************************************
	// decode
	// ************************************************
	always @* begin
		pc_next = pc_o + `BBS_PC_ONE;
		sr_next = sr;
		rd_next = rd_val;
		rd_we   = 1'b0;
		taken   = 1'b0;
		io_op   = 1'b0;
		io_val  = 1'b0;
		io_word = io_mem[op_io_addr_i];
		case (op_code_i)
			`BBS_OP_BRANCH_ON_NO_CARRY: taken = ~sr[`BBS_FLAG_C];
			`BBS_OP_BRANCH_UNSIGNED_GE: taken = ~sr[`BBS_FLAG_C];
			`BBS_OP_BRANCH_UNSIGNED_LT: taken = sr[`BBS_FLAG_C];
			`BBS_OP_BRANCH_ON_NEGATIVE: taken = sr[`BBS_FLAG_N];
			`BBS_OP_BRANCH_ON_POSITIVE: taken = ~sr[`BBS_FLAG_N];
			`BBS_OP_BRANCH_SIGNED_GE: taken = ~(sr[`BBS_FLAG_N] ^ sr[`BBS_FLAG_V]);
			`BBS_OP_BRANCH_SIGNED_LT: taken = sr[`BBS_FLAG_N] ^ sr[`BBS_FLAG_V];
			`BBS_OP_BRANCH_HC_SET: taken = sr[`BBS_FLAG_H];
			`BBS_OP_BRANCH_HC_CLEAR: taken = ~sr[`BBS_FLAG_H];
			`BBS_OP_BRANCH_T_SET: taken = sr[`BBS_FLAG_T];
			`BBS_OP_BRANCH_IRQ_ON: taken = sr[`BBS_FLAG_I];
			`BBS_OP_BRANCH_IRQ_OFF: taken = ~sr[`BBS_FLAG_I];
			`BBS_OP_SET_IO_BIT: begin
				io_op  = 1'b1;
				io_val = 1'b1;
			end
			`BBS_OP_CLEAR_IO_BIT: begin
				io_op  = 1'b1;
				io_val = 1'b0;
			end
			`BBS_OP_LOGICAL_SHIFT_UP: begin
				rd_next = {rd_val[6:0], 1'b0};
				rd_we   = 1'b1;
				sr_next = shift_flags(sr, rd_next, rd_val[7]);
			end
			`BBS_OP_LOGICAL_SHIFT_DOWN: begin
				rd_next = {1'b0, rd_val[7:1]};
				rd_we   = 1'b1;
				sr_next = shift_flags(sr, rd_next, rd_val[0]);
			end
			`BBS_OP_ROTATE_UP_CARRY: begin
				rd_next = {rd_val[6:0], sr[`BBS_FLAG_C]};
				rd_we   = 1'b1;
				sr_next = shift_flags(sr, rd_next, rd_val[7]);
			end
			`BBS_OP_ROTATE_DOWN_CARRY: begin
				rd_next = {sr[`BBS_FLAG_C], rd_val[7:1]};
				rd_we   = 1'b1;
				sr_next = shift_flags(sr, rd_next, rd_val[0]);
			end
			`BBS_OP_ARITH_SHIFT_DOWN: begin
				rd_next = {rd_val[7], rd_val[7:1]};
				rd_we   = 1'b1;
				sr_next = shift_flags(sr, rd_next, rd_val[0]);
			end
			`BBS_OP_SWAP_NIBBLES: begin
				rd_next = {rd_val[3:0], rd_val[7:4]};
				rd_we   = 1'b1;
			end
			`BBS_OP_FLAG_BIT_SET: sr_next[op_bit_i] = 1'b1;
			`BBS_OP_FLAG_BIT_CLEAR: sr_next[op_bit_i] = 1'b0;
			`BBS_OP_STORE_BIT_TO_T: sr_next[`BBS_FLAG_T] = rd_val[op_bit_i];
			`BBS_OP_LOAD_BIT_FROM_T: begin
				rd_next[op_bit_i] = sr[`BBS_FLAG_T];
				rd_we = 1'b1;
			end
			default: begin
				sr_next = sr;
			end
		endcase
		io_word[op_bit_i] = io_val;
		// offset is sign-extended; target is pc + k + 1
		if (taken)
			pc_next = pc_o + {{(`BBS_PC_W-7){op_offset_i[6]}}, op_offset_i} + `BBS_PC_ONE;
	end

	// ************************************************
	// sequencing
	// ************************************************
	// taken branches and io bit ops hold ready low one extra cycle
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			state_reg         <= ST_IDLE;
			op_ready_o        <= 1'b1;
			op_done_o         <= 1'b0;
			pc_o              <= `BBS_PC_RESET;
			status_register_o <= `BBS_SR_RESET;
			result_o          <= `BBS_REG_RESET;
			io_addr_o         <= {`BBS_IO_ADDR_W{1'b0}};
			io_data_o         <= `BBS_IO_RESET;
			io_we_o           <= 1'b0;
			for (i = 0; i < `BBS_RF_DEPTH; i = i + 1) begin
				rf_mem[i] <= `BBS_REG_RESET;
				io_mem[i] <= `BBS_IO_RESET;
			end
		end else begin
			op_done_o <= 1'b0;
			io_we_o   <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (op_valid_i) begin
						pc_o              <= pc_next;
						status_register_o <= sr_next;
						if (rd_we) begin
							rf_mem[op_reg_i] <= rd_next;
							result_o         <= rd_next;
						end
						if (io_op) begin
							io_mem[op_io_addr_i] <= io_word;
							io_addr_o            <= op_io_addr_i;
							io_data_o            <= io_word;
							io_we_o              <= 1'b1;
						end
						if (taken || io_op) begin
							state_reg  <= ST_WAIT;
							op_ready_o <= 1'b0;
						end else begin
							op_done_o <= 1'b1;
						end
					end
				end
				ST_WAIT: begin
					state_reg  <= ST_IDLE;
					op_ready_o <= 1'b1;
					op_done_o  <= 1'b1;
				end
				default: begin
					state_reg  <= ST_IDLE;
					op_ready_o <= 1'b1;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> src/bbs_defs.vh
`ifndef BBS_DEFS_VH
`define BBS_DEFS_VH
// ************************************************
// operation codes
// ************************************************
`define BBS_OP_W                  5
`define BBS_OP_BRANCH_ON_NO_CARRY 5'h00
`define BBS_OP_BRANCH_UNSIGNED_GE 5'h01
`define BBS_OP_BRANCH_UNSIGNED_LT 5'h02
`define BBS_OP_BRANCH_ON_NEGATIVE 5'h03
`define BBS_OP_BRANCH_ON_POSITIVE 5'h04
`define BBS_OP_BRANCH_SIGNED_GE   5'h05
`define BBS_OP_BRANCH_SIGNED_LT   5'h06
`define BBS_OP_BRANCH_HC_SET      5'h07
`define BBS_OP_BRANCH_HC_CLEAR    5'h08
`define BBS_OP_BRANCH_T_SET       5'h09
`define BBS_OP_BRANCH_IRQ_ON      5'h0a
`define BBS_OP_BRANCH_IRQ_OFF     5'h0b
`define BBS_OP_SET_IO_BIT         5'h0c
`define BBS_OP_CLEAR_IO_BIT       5'h0d
`define BBS_OP_LOGICAL_SHIFT_UP   5'h0e
`define BBS_OP_LOGICAL_SHIFT_DOWN 5'h0f
`define BBS_OP_ROTATE_UP_CARRY    5'h10
`define BBS_OP_ROTATE_DOWN_CARRY  5'h11
`define BBS_OP_ARITH_SHIFT_DOWN   5'h12
`define BBS_OP_SWAP_NIBBLES       5'h13
`define BBS_OP_FLAG_BIT_SET       5'h14
`define BBS_OP_FLAG_BIT_CLEAR     5'h15
`define BBS_OP_STORE_BIT_TO_T     5'h16
`define BBS_OP_LOAD_BIT_FROM_T    5'h17
// ************************************************
// status register bit positions
// ************************************************
`define BBS_FLAG_C 0
`define BBS_FLAG_Z 1
`define BBS_FLAG_N 2
`define BBS_FLAG_V 3
`define BBS_FLAG_S 4
`define BBS_FLAG_H 5
`define BBS_FLAG_T 6
`define BBS_FLAG_I 7
// ************************************************
// widths and reset values
// ************************************************
`define BBS_PC_W      16
`define BBS_PC_RESET  16'h0000
`define BBS_SR_RESET  8'h00
`define BBS_REG_RESET 8'h00
`define BBS_IO_RESET  8'h00
`define BBS_IO_ADDR_W 5
`define BBS_IO_DEPTH  32
`define BBS_RF_ADDR_W 5
`define BBS_RF_DEPTH  32
`define BBS_PC_ONE    16'h0001
`endif

// >>> verification/bbs_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "bbs_defs.vh"
module bbs_checker (
	input wire                 core_clk_i,
	input wire                 reset_i,
	input wire                 op_valid_i,
	input wire [`BBS_OP_W-1:0] op_code_i,
	input wire [2:0]           op_bit_i,
	input wire [6:0]           op_offset_i,
	input wire                 op_ready_o,
	input wire                 op_done_o,
	input wire [`BBS_PC_W-1:0] pc_o,
	input wire [7:0]           status_register_o,
	input wire [7:0]           io_data_o,
	input wire                 io_we_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	wire        tk = op_valid_i && op_ready_o;
	wire        br = tk && op_code_i < 5'h0c;
	wire        io = tk && (op_code_i == 5'h0c || op_code_i == 5'h0d);
	wire [15:0] sk = {{9{op_offset_i[6]}}, op_offset_i};
	sequence s_busy; io_we_o && !op_ready_o; endsequence
	sequence s_fin; op_done_o && op_ready_o; endsequence
	a_io_steps: assert property (io |=> s_busy ##1 s_fin)
		else $error("io op timing wrong");
	a_io_value: assert property (io |=> io_data_o[$past(op_bit_i)] == ($past(op_code_i) == 5'h0c))
		else $error("io bit value wrong");
	a_we_pulse: assert property (io_we_o |=> !io_we_o)
		else $error("io write not a pulse");
	a_busy_end: assert property (!op_ready_o |=> s_fin)
		else $error("busy longer than one cycle");
	a_branch_pc: assert property (br |=> pc_o == $past(pc_o) + 16'h0001 + (op_ready_o ? 16'h0000 : $past(sk)))
		else $error("branch target wrong");
	a_branch_flags: assert property (br |=> $stable(status_register_o))
		else $error("branch changed flags");
	a_one_cycle: assert property (tk && op_code_i > 5'h0d && op_code_i < 5'h18 |=> s_fin)
		else $error("single cycle op slow");
	a_keep_flags: assert property (tk && (op_code_i == 5'h13 || op_code_i == 5'h17) |=> $stable(status_register_o))
		else $error("flags changed");
	a_flag_write: assert property (tk && (op_code_i == 5'h14 || op_code_i == 5'h15) |=> status_register_o[$past(op_bit_i)] == ($past(op_code_i) == 5'h14))
		else $error("flag bit not written");
endmodule
bind bbs_core bbs_checker u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
	.op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_bit_i(op_bit_i),
	.op_offset_i(op_offset_i), .op_ready_o(op_ready_o), .op_done_o(op_done_o), .pc_o(pc_o),
	.status_register_o(status_register_o), .io_data_o(io_data_o), .io_we_o(io_we_o));
`default_nettype wire

// >>> verification/branch_bit_shift_ops_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin checks++; if ((a) !== (b)) begin err_count++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module branch_bit_shift_ops_test;
	reg        clk = 0, rst = 1, vld = 0;
	reg  [4:0] code = 0, rg = 0;
	reg  [2:0] bt = 0;
	reg  [6:0] k = 0;
	wire       rdy, done, we;
	wire [15:0] pc;
	wire [7:0] sr, res, iod;
	wire [4:0] ioa;
	integer    err_count = 0, checks = 0;
	bbs_core DUT (.core_clk_i(clk), .reset_i(rst), .op_valid_i(vld), .op_code_i(code),
		.op_reg_i(rg), .op_io_addr_i(rg), .op_bit_i(bt), .op_offset_i(k), .op_ready_o(rdy),
		.op_done_o(done), .pc_o(pc), .status_register_o(sr), .result_o(res), .io_addr_o(ioa),
		.io_data_o(iod), .io_we_o(we));
	initial forever #50 clk = ~clk;
	// ************************************************
	// drivers
	// ************************************************
	// idle cycle first so valid never toggles twice in one step
	task op(input [4:0] c, input [4:0] r, input [2:0] b, input [6:0] o); begin
		@(posedge clk) #10;
		code = c; rg = r; bt = b; k = o; vld = 1;
		while (rdy !== 1'b1) @(posedge clk) #10;
		@(posedge clk) #10;
		vld = 0;
	end endtask
	task setsr(input [7:0] s); integer i; begin
		for (i = 0; i < 8; i++) op(s[i] ? 5'h14 : 5'h15, 0, i, 0);
	end endtask
	function taken(input [4:0] c, input [7:0] s);
		case (c)
			0, 1: taken = !s[0];
			2: taken = s[0];
			3: taken = s[2];
			4: taken = !s[2];
			5: taken = !(s[2] ^ s[3]);
			6: taken = s[2] ^ s[3];
			7: taken = s[5];
			8: taken = !s[5];
			9: taken = s[6];
			10: taken = s[7];
			default: taken = !s[7];
		endcase
	endfunction
	// ************************************************
	// scenarios
	// ************************************************
	task t_flags; begin
		setsr(8'hff); `CHK(sr, 8'hff)
		setsr(8'ha5); `CHK(sr, 8'ha5)
	end endtask
	task t_branch; reg [15:0] p; reg [7:0] s; reg [6:0] o; reg t; integer c, j; begin
		for (c = 0; c < 12; c++) for (j = 0; j < 3; j++) begin
			s = j == 0 ? 8'h00 : j == 1 ? 8'hff : 8'h04;
			o = j == 1 ? 7'h7d : 7'h05;
			setsr(s); p = pc; op(c, 0, 0, o); t = taken(c, s);
			`CHK(pc, p + 16'h0001 + (t ? {{9{o[6]}}, o} : 16'h0000))
			`CHK({rdy, sr}, {!t, s})
		end
	end endtask
	task t_io; begin
		op(5'h0c, 5, 3, 0); `CHK({we, ioa, iod, rdy}, {1'b1, 5'h05, 8'h08, 1'b0})
		op(5'h0c, 5, 0, 0); `CHK(iod, 8'h09)
		op(5'h0d, 5, 3, 0); `CHK({we, iod, sr}, {1'b1, 8'h01, 8'h04})
	end endtask
	task t_shift; integer i;
		reg [34:0] cs; reg [55:0] rs; reg [27:0] ns; begin
		cs = {5'h0e, 5'h10, 5'h11, 5'h11, 5'h12, 5'h0f, 5'h13};
		rs = 56'h02050281c06006; ns = 28'h909c500;
		setsr(8'h40); op(5'h17, 2, 7, 0); op(5'h17, 2, 0, 0);
		`CHK({res, sr}, {8'h81, 8'h40})
		for (i = 0; i < 7; i++) begin
			op(cs[34-5*i -: 5], 2, 0, 0);
			`CHK({done, res, sr}, {1'b1, rs[55-8*i -: 8], 4'h4, ns[27-4*i -: 4]})
		end
		op(5'h16, 2, 0, 0); `CHK(sr[6], 1'b0)
		op(5'h16, 2, 2, 0); `CHK(sr, 8'h40)
	end endtask
	task results; begin
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	end endtask
	initial begin
		#1000000 err_count++;
		results;
	end
	initial begin
		repeat (6) @(posedge clk);
		#10 rst = 0;
		`CHK({pc, sr, rdy}, {16'h0000, 8'h00, 1'b1})
		t_flags; t_branch; t_io; t_shift;
		results;
	end
endmodule
`default_nettype wire
